// File: core/rfaf_regs.svh
// register offsets, field positions, codes and timing figures of the address filter
// assumes a 12-bit APB byte address and a 200 MHz pclk
`ifndef RFAF_REGS_SVH
`define RFAF_REGS_SVH

`define RFAF_ADDR_W 12
`define RFAF_OFF_NETMODE 12'h000
`define RFAF_OFF_AUTOADDR 12'h004
`define RFAF_OFF_UID_DEST 12'h008
`define RFAF_OFF_USER_DEST 12'h00c
`define RFAF_OFF_USER_SRC 12'h010
`define RFAF_OFF_USER_MASK 12'h014
`define RFAF_OFF_CUST 12'h018
`define RFAF_OFF_MY_UID 12'h01c
`define RFAF_OFF_TXQ 12'h020
`define RFAF_OFF_STATUS 12'h024

`define RFAF_MODE_UID 3'h4
`define RFAF_MODE_USER 3'h6
`define RFAF_MODE_EXT 3'h7
`define RFAF_MODE_ACK_BIT 4
`define RFAF_NETMODE_RST 8'h04

`define RFAF_UID_BCAST 32'h0fffffff
`define RFAF_ALL_ONES 32'hffffffff
`define RFAF_USER_WIDTH 32'h0000ffff
`define RFAF_EX_NO_ACK 8'h20
`define RFAF_ST_BE_BIT 0
`define RFAF_ST_EX_LSB 8
`define RFAF_ST_EX_MSB 15

`define RFAF_PCLK_NS 5
`define RFAF_ACK_WAIT_NS 1000000
`define RFAF_MAX_RETRY 3

`endif

// File: core/rfaf_pkg.sv
// types shared by the address filter and its bench
// assumes rfaf_regs.svh holds every number
package rfaf_pkg;

	typedef enum logic [1:0] {
		rfaf_addr_uid,
		rfaf_addr_user,
		rfaf_addr_ext
	} rfaf_addr_t;

	typedef enum logic [1:0] {
		rfaf_tx_idle,
		rfaf_tx_send,
		rfaf_tx_wait_ack
	} rfaf_tx_state_t;

endpackage : rfaf_pkg

// File: core/rfaf_filter_ack.sv
// address building, receive filtering and assured delivery of a hopping radio
// assumes the radio framer runs on pclk: headers arrive as one-cycle strobes
//
// How it works
// - fixed 4-byte factory id, read only, is the address in unique-id mode.
// - unique-id transmit: own id as source, destination register as destination.
// - unique-id receive: deliver only when destination equals own id or is broadcast, else ignore.
// - broadcast unique-id destination is delivered everywhere with no acknowledgement.
// - mode 0x04 unique-id plain, 0x14 unique-id with acknowledgement.
// - modes 0x06/0x16 user, 0x07/0x17 extended user, without/with acknowledgement.
// - user destination is fixed customer code plus two user destination bytes.
// - user local address is two source bytes; two-byte mask for sub-networks.
// - deliver when masked local address equals masked received destination.
// - customer code compared unmasked and must match in user modes.
// - acknowledge only on exact source equals destination; mask not applied.
// - deliver when masked destination equals the mask itself: network broadcast.
// - all-ones mask means exact address equality or the all-ones network broadcast only.
// - extended user mode is user mode with four-byte fields.
// - with acknowledgement, wait a timeout then retransmit if none arrived.
// - duplicate packet: payload dropped but acknowledgement still returned.
// - acknowledgement sent right after reception, no backoff.
// - acknowledgement completes the block; last block raises buffer empty.
// - receiver applies the packet's own addressing type, discards mismatches.
// - auto addressing copies received source into the destination register.
// - retries exhausted records the no-acknowledgement exception code.
//
// Decided for this implementation: the APB slave port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
`include "rfaf_regs.svh"

module rfaf_filter_ack
	import rfaf_pkg::*;
#(
	parameter logic [31:0] FACTORY_UID = 32'h0000_0001, // arbitrary value
	parameter logic [15:0] CUSTOMER_CODE = 16'h0001, // arbitrary value
	parameter int unsigned ACK_WAIT_CYCLES = `RFAF_ACK_WAIT_NS / `RFAF_PCLK_NS,
	parameter int unsigned MAX_RETRIES = `RFAF_MAX_RETRY,
	parameter int unsigned QUEUE_W = 8
) (
	input wire logic pclk, // bus clock
	input wire logic presetn, // async reset, low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb write
	input wire logic [`RFAF_ADDR_W-1:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // unmapped address
	input wire logic rx_hdr_valid, // received header strobe
	input wire rfaf_addr_t rx_addr_type, // addressing of received packet
	input wire logic rx_is_ack, // received packet is an ack
	input wire logic rx_ack_req, // sender wants an ack
	input wire logic [7:0] rx_seq, // sequence id
	input wire logic [31:0] rx_src, // received source
	input wire logic [31:0] rx_dst, // received destination
	input wire logic [15:0] rx_cust, // received customer code
	output logic rx_deliver, // payload to uart, pulse
	output logic rx_discard, // payload dropped, pulse
	output logic ack_send, // send ack now, pulse
	output rfaf_addr_t ack_type, // addressing of the ack
	output logic [31:0] ack_dst, // ack goes to this source
	output logic [7:0] ack_seq, // sequence id echoed
	output logic tx_pkt_valid, // launch packet, pulse
	output rfaf_addr_t tx_addr_type, // tx addressing
	output logic tx_ack_req, // tx asks for ack
	output logic [7:0] tx_seq, // tx sequence id
	output logic [31:0] tx_src, // tx source
	output logic [31:0] tx_dst, // tx destination
	output logic [15:0] tx_cust, // tx customer code
	input wire logic tx_done, // radio finished packet, pulse
	output logic buffer_empty_line, // no block pending, high
	output logic no_ack_exception // retries exhausted, pulse
);

	if (MAX_RETRIES < 1 || MAX_RETRIES > 255 || ACK_WAIT_CYCLES < 1 || QUEUE_W < 1 || QUEUE_W > 32) begin : g_chk
		$error("rfaf_filter_ack: parameter out of range");
	end

	function automatic logic [31:0] width_mask(input rfaf_addr_t t);
		width_mask = (t == rfaf_addr_user) ? `RFAF_USER_WIDTH : `RFAF_ALL_ONES;
	endfunction : width_mask

	function automatic rfaf_addr_t mode_type(input logic [2:0] m);
		mode_type = (m == `RFAF_MODE_EXT) ? rfaf_addr_ext :
			(m == `RFAF_MODE_USER) ? rfaf_addr_user : rfaf_addr_uid;
	endfunction : mode_type

	logic [7:0] net_mode;
	logic auto_addr;
	logic [31:0] uid_dest;
	logic [31:0] user_dest;
	logic [31:0] user_src;
	logic [31:0] user_mask;
	logic [7:0] exception;
	logic [QUEUE_W-1:0] queue;
	logic [7:0] retries;
	logic [31:0] timer;
	logic last_ok;
	logic [31:0] last_src;
	logic [7:0] last_seq;
	rfaf_tx_state_t state;
	rfaf_tx_state_t next_state;

	// apb decode
	wire setup = psel && !penable;
	wire access = psel && penable;
	wire wr = access && pwrite;
	wire hit_net = paddr == `RFAF_OFF_NETMODE;
	wire hit_auto = paddr == `RFAF_OFF_AUTOADDR;
	wire hit_uid = paddr == `RFAF_OFF_UID_DEST;
	wire hit_udst = paddr == `RFAF_OFF_USER_DEST;
	wire hit_usrc = paddr == `RFAF_OFF_USER_SRC;
	wire hit_umsk = paddr == `RFAF_OFF_USER_MASK;
	wire hit_cust = paddr == `RFAF_OFF_CUST;
	wire hit_myid = paddr == `RFAF_OFF_MY_UID;
	wire hit_txq = paddr == `RFAF_OFF_TXQ;
	wire hit_stat = paddr == `RFAF_OFF_STATUS;
	wire hit_any = hit_net || hit_auto || hit_uid || hit_udst || hit_usrc ||
		hit_umsk || hit_cust || hit_myid || hit_txq || hit_stat;
	wire [31:0] status_word = {16'h0000, exception, 7'h00, buffer_empty_line};
	wire [31:0] rd_mux =
		hit_net ? {24'h000000, net_mode} :
		hit_auto ? {31'h00000000, auto_addr} :
		hit_uid ? uid_dest :
		hit_udst ? user_dest :
		hit_usrc ? user_src :
		hit_umsk ? user_mask :
		hit_cust ? {16'h0000, CUSTOMER_CODE} :
		hit_myid ? FACTORY_UID :
		hit_txq ? 32'(queue) :
		hit_stat ? status_word : 32'h00000000;

	assign pready = 1'b1;
	assign pslverr = access && !hit_any;

	// receive addressing, by the packet's own type
	wire [31:0] rx_wm = width_mask(rx_addr_type);
	wire [31:0] rx_dst_w = rx_dst & rx_wm;
	wire [31:0] src_w = user_src & rx_wm;
	wire [31:0] msk_w = user_mask & rx_wm;
	wire cust_ok = rx_cust == CUSTOMER_CODE;
	wire uid_bcast = rx_dst == `RFAF_UID_BCAST || rx_dst == `RFAF_ALL_ONES;
	wire is_uid = rx_addr_type == rfaf_addr_uid;
	wire user_hit = cust_ok && ((rx_dst_w & msk_w) == (src_w & msk_w) ||
		(rx_dst_w & msk_w) == msk_w);
	wire for_me = is_uid ? (rx_dst == FACTORY_UID || uid_bcast) : user_hit;
	// ack target ignores the mask so masked groups never answer together
	wire exact = is_uid ? rx_dst == FACTORY_UID : cust_ok && rx_dst_w == src_w;
	wire rx_data = rx_hdr_valid && !rx_is_ack;
	wire dup_hit = last_ok && rx_ack_req && rx_src == last_src && rx_seq == last_seq;
	wire ack_needed = rx_data && rx_ack_req && exact;
	wire next_deliver = rx_data && for_me && !dup_hit;

	// transmit addressing
	wire ack_en = net_mode[`RFAF_MODE_ACK_BIT];
	wire rfaf_addr_t cfg_type = mode_type(net_mode[2:0]);
	wire [31:0] tx_wm = width_mask(tx_addr_type);
	wire [31:0] own_addr = (tx_addr_type == rfaf_addr_uid) ? FACTORY_UID : user_src & tx_wm;
	wire ack_hit = rx_hdr_valid && rx_is_ack && rx_seq == tx_seq && (rx_dst & tx_wm) == own_addr;
	wire expire = state == rfaf_tx_wait_ack && !ack_hit && timer == 32'h00000001;
	wire fail = expire && retries == 8'(MAX_RETRIES);
	wire block_done = (state == rfaf_tx_send && tx_done && !tx_ack_req) ||
		(state == rfaf_tx_wait_ack && ack_hit) || fail;
	wire launch = (state == rfaf_tx_idle && queue != '0) || (expire && !fail);
	wire q_add = wr && hit_txq && queue != '1;
	wire exc_clr = access && !pwrite && hit_stat &&
		exception == prdata[`RFAF_ST_EX_MSB:`RFAF_ST_EX_LSB];

	// buffer empty follows the block counter register directly
	assign buffer_empty_line = queue == '0;

	always_comb begin
		next_state = state;
		case (state)
			rfaf_tx_idle: if (launch) next_state = rfaf_tx_send;
			rfaf_tx_send: if (tx_done) next_state = tx_ack_req ? rfaf_tx_wait_ack : rfaf_tx_idle;
			rfaf_tx_wait_ack: begin
				if (ack_hit || fail) next_state = rfaf_tx_idle;
				else if (expire) next_state = rfaf_tx_send;
			end
			default: next_state = rfaf_tx_idle;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= rfaf_tx_idle;
			queue <= '0;
			retries <= 8'h00;
			timer <= 32'h00000000;
		end else begin
			state <= next_state;
			queue <= queue + QUEUE_W'(q_add) - QUEUE_W'(block_done);
			if (state == rfaf_tx_idle) retries <= 8'h00;
			else if (expire) retries <= retries + 8'h01;
			if (state == rfaf_tx_send && tx_done) timer <= 32'(ACK_WAIT_CYCLES);
			else if (timer != 32'h00000000) timer <= timer - 32'h00000001;
		end
	end

	// header fields are frozen at launch so a retry repeats the same packet
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tx_pkt_valid <= 1'b0;
			tx_addr_type <= rfaf_addr_uid;
			tx_ack_req <= 1'b0;
			tx_seq <= 8'h00;
			tx_src <= 32'h00000000;
			tx_dst <= 32'h00000000;
			tx_cust <= 16'h0000;
		end else begin
			tx_pkt_valid <= launch;
			if (launch && state == rfaf_tx_idle) begin
				tx_addr_type <= cfg_type;
				tx_ack_req <= ack_en;
				tx_seq <= tx_seq + 8'h01;
				tx_cust <= CUSTOMER_CODE;
				if (cfg_type == rfaf_addr_uid) begin
					tx_src <= FACTORY_UID;
					tx_dst <= uid_dest;
				end else begin
					tx_src <= user_src & width_mask(cfg_type);
					tx_dst <= user_dest & width_mask(cfg_type);
				end
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rx_deliver <= 1'b0;
			rx_discard <= 1'b0;
			ack_send <= 1'b0;
			ack_type <= rfaf_addr_uid;
			ack_dst <= 32'h00000000;
			ack_seq <= 8'h00;
			last_ok <= 1'b0;
			last_src <= 32'h00000000;
			last_seq <= 8'h00;
			no_ack_exception <= 1'b0;
		end else begin
			rx_deliver <= next_deliver;
			rx_discard <= rx_data && !next_deliver;
			ack_send <= ack_needed;
			no_ack_exception <= fail;
			if (ack_needed) begin
				ack_type <= rx_addr_type;
				ack_dst <= rx_src;
				ack_seq <= rx_seq;
			end
			if (rx_data && rx_ack_req && for_me) begin
				last_ok <= 1'b1;
				last_src <= rx_src;
				last_seq <= rx_seq;
			end
		end
	end

	// registers; auto addressing wins over a bus write in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			net_mode <= `RFAF_NETMODE_RST;
			auto_addr <= 1'b0;
			uid_dest <= 32'h00000000;
			user_dest <= 32'h00000000;
			user_src <= 32'h00000000;
			user_mask <= `RFAF_ALL_ONES;
			exception <= 8'h00;
			prdata <= 32'h00000000;
		end else begin
			if (setup) prdata <= rd_mux;
			if (wr && hit_net) net_mode <= pwdata[7:0];
			if (wr && hit_auto) auto_addr <= pwdata[0];
			if (wr && hit_usrc) user_src <= pwdata;
			if (wr && hit_umsk) user_mask <= pwdata;
			if (auto_addr && next_deliver && is_uid) uid_dest <= rx_src;
			else if (wr && hit_uid) uid_dest <= pwdata;
			if (auto_addr && next_deliver && !is_uid) user_dest <= rx_src & rx_wm;
			else if (wr && hit_udst) user_dest <= pwdata;
			// a new exception in the clearing cycle survives the clear
			if (fail) exception <= `RFAF_EX_NO_ACK;
			else if (exc_clr) exception <= 8'h00;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_wait_expire;
		state == rfaf_tx_wait_ack && !ack_hit && timer == 32'h00000001 && retries < 8'(MAX_RETRIES);
	endsequence

	sequence s_ack_last;
		state == rfaf_tx_wait_ack && ack_hit && queue == QUEUE_W'(1) && !q_add;
	endsequence

	a_uid_accept: assert property (
		rx_data && is_uid && rx_dst == FACTORY_UID && !dup_hit |=> rx_deliver)
		else $error("own unique id not delivered");
	a_uid_ignore: assert property (
		rx_data && is_uid && rx_dst != FACTORY_UID && !uid_bcast |=> !rx_deliver && rx_discard)
		else $error("foreign unique id delivered");
	a_bcast_no_ack: assert property (
		rx_data && is_uid && uid_bcast |=> rx_deliver == !$past(dup_hit) && !ack_send)
		else $error("broadcast mishandled");
	a_cust_gate: assert property (
		rx_data && !is_uid && !cust_ok |=> !rx_deliver && !ack_send)
		else $error("customer code not enforced");
	a_ack_exact: assert property (
		rx_data && !is_uid && rx_dst_w != src_w |=> !ack_send)
		else $error("ack sent without exact match");
	a_dup_drop: assert property (
		rx_data && dup_hit && exact |=> !rx_deliver && ack_send)
		else $error("duplicate delivered or not acked");
	a_retry_send: assert property (
		s_wait_expire |=> tx_pkt_valid ##1 state == rfaf_tx_send)
		else $error("no retransmit after timeout");
	a_be_on_ack: assert property (
		s_ack_last |=> buffer_empty_line && state == rfaf_tx_idle)
		else $error("last ack did not empty buffer");
	a_no_ack_code: assert property (
		fail |=> exception == `RFAF_EX_NO_ACK && no_ack_exception)
		else $error("no-ack exception missing");
	a_uid_source: assert property (
		tx_pkt_valid && tx_addr_type == rfaf_addr_uid |-> tx_src == FACTORY_UID)
		else $error("unique-id source wrong");

	// a user or extended header that passes the customer gate and is not a repeat
	sequence s_user_pass;
		rx_data && !is_uid && cust_ok && !dup_hit;
	endsequence

	a_rx_one_verdict: assert property (
		rx_data |=> rx_deliver != rx_discard)
		else $error("data header without a single verdict");
	a_ack_pkt_quiet: assert property (
		rx_hdr_valid && rx_is_ack |=> !rx_deliver && !rx_discard && !ack_send)
		else $error("ack packet produced a receive verdict");
	a_ack_fields: assert property (
		ack_needed |=> ack_send && ack_dst == $past(rx_src) && ack_seq == $past(rx_seq))
		else $error("ack not aimed back at the sender");
	a_exact_ack: assert property (
		rx_data && rx_ack_req && !is_uid && cust_ok && rx_dst_w == src_w |=> ack_send)
		else $error("exact user match not acknowledged");
	a_user_match: assert property (
		s_user_pass ##0 (rx_dst_w & msk_w) == (src_w & msk_w) |=> rx_deliver)
		else $error("masked user match not delivered");
	a_net_bcast: assert property (
		s_user_pass ##0 (rx_dst_w & msk_w) == msk_w |=> rx_deliver)
		else $error("network broadcast not delivered");
	a_auto_copy: assert property (
		auto_addr && next_deliver && is_uid |=> uid_dest == $past(rx_src))
		else $error("auto address not copied");
	a_tx_cust: assert property (
		tx_pkt_valid |-> tx_cust == CUSTOMER_CODE)
		else $error("customer code not sent");
	// transmit state machine: plain completion, ack wait start, retry bound, buffer empty only while idle
	a_plain_done: assert property (
		state == rfaf_tx_send && tx_done && !tx_ack_req |=> state == rfaf_tx_idle)
		else $error("block without ack not completed");
	a_timer_load: assert property (
		state == rfaf_tx_send && tx_done && tx_ack_req |=> state == rfaf_tx_wait_ack && timer == 32'(ACK_WAIT_CYCLES))
		else $error("ack wait not started");
	a_retry_bound: assert property (
		state != rfaf_tx_idle |-> retries <= 8'(MAX_RETRIES))
		else $error("retry count overran");
	a_be_idle: assert property (
		buffer_empty_line |-> state == rfaf_tx_idle)
		else $error("buffer empty while a block is in flight");

endmodule : rfaf_filter_ack

`default_nettype wire

// File: test/rfaf_peer.sv
// peer transceiver model: finishes each launch and may return an acknowledgement
// assumes the bench injects received headers through send_hdr and sets ack_dly
`timescale 1ns/1ps
`default_nettype none

module rfaf_peer
	import rfaf_pkg::*;
(
	input wire logic pclk, // clock
	input wire logic tx_pkt_valid, // launch from device
	input wire rfaf_addr_t tx_addr_type, // tx addressing
	input wire logic tx_ack_req, // ack wanted
	input wire logic [7:0] tx_seq, // tx sequence
	input wire logic [31:0] tx_src, // tx source
	input wire logic [31:0] tx_dst, // tx destination
	input wire logic [15:0] tx_cust, // tx customer code
	output var logic tx_done, // packet sent
	output var logic rx_hdr_valid, // header strobe
	output var rfaf_addr_t rx_addr_type, // rx addressing
	output var logic rx_is_ack, // ack packet
	output var logic rx_ack_req, // ack wanted
	output var logic [7:0] rx_seq, // rx sequence
	output var logic [31:0] rx_src, // rx source
	output var logic [31:0] rx_dst, // rx destination
	output var logic [15:0] rx_cust // rx customer code
);
	int ack_dly = 1; // 0: never answers, forces retries
	int done_cnt = 0;
	int ack_cnt = 0;

	initial begin
		{tx_done, rx_hdr_valid, rx_is_ack, rx_ack_req} = 4'h0;
		{rx_seq, rx_src, rx_dst, rx_cust} = '0;
		rx_addr_type = rfaf_addr_uid;
	end

	// fields are only valid with the strobe; source and destination inverted afterwards so stale values never match
	task send_hdr(input rfaf_addr_t t, input logic r, input logic [7:0] s, input logic [31:0] sr, input logic [31:0] d,
		input logic [15:0] c);
		@(posedge pclk);
		rx_hdr_valid <= 1'b1;
		{rx_addr_type, rx_ack_req, rx_seq, rx_src, rx_dst, rx_cust} <= {t, r, s, sr, d, c};
		@(posedge pclk);
		rx_hdr_valid <= 1'b0;
		rx_src <= ~sr;
		rx_dst <= ~d;
	endtask : send_hdr

	always @(posedge pclk) begin
		tx_done <= 1'b0;
		if (rx_hdr_valid && rx_is_ack) begin
			rx_hdr_valid <= 1'b0;
			rx_is_ack <= 1'b0;
			rx_dst <= ~rx_dst;
		end
		if (tx_pkt_valid)
			done_cnt <= 3;
		else if (done_cnt == 1) begin
			tx_done <= 1'b1;
			done_cnt <= 0;
			if (tx_ack_req && ack_dly > 0)
				ack_cnt <= ack_dly;
		end else if (done_cnt > 1)
			done_cnt <= done_cnt - 1;
		if (ack_cnt == 1) begin
			// answer addressed back to the sender, echoing its sequence id
			rx_hdr_valid <= 1'b1;
			rx_is_ack <= 1'b1;
			{rx_addr_type, rx_ack_req, rx_seq, rx_cust} <= {tx_addr_type, 1'b0, tx_seq, tx_cust};
			rx_src <= tx_dst;
			rx_dst <= tx_src;
			ack_cnt <= 0;
		end else if (ack_cnt > 1)
			ack_cnt <= ack_cnt - 1;
	end
endmodule : rfaf_peer

`default_nettype wire

// File: test/rf_address_filter_ack_test.sv
// self-checking bench of the address filter: apb setup, receive filtering, transmit and retries
// assumes rfaf_peer answers launches; ack timeout shortened to 20 cycles
`timescale 1ns/1ps
`default_nettype none
`include "rfaf_regs.svh"
`define CHK(g, x, m) begin compares++; if ((g) !== (x)) begin err_count++; $display("CHECK FAILED %0t %s", $time, m); end end

module rf_address_filter_ack_test;
	import rfaf_pkg::*;
	localparam logic [31:0] FID = 32'h0000_2000; // arbitrary value
	localparam logic [15:0] CC = 16'h5a3c; // arbitrary value
	localparam int MAXR = 3;
	localparam logic [7:0] MODES [6] = '{8'h04, 8'h14, 8'h06, 8'h16, 8'h07, 8'h17};
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, last_err;
	logic [11:0] paddr = '0;
	logic [31:0] pwdata = '0, prdata, rd, rx_src, rx_dst, ack_dst, tx_src, tx_dst, w, ts, td;
	logic rx_hdr_valid, rx_is_ack, rx_ack_req, rx_deliver, rx_discard, ack_send;
	logic tx_pkt_valid, tx_ack_req, tx_done, buffer_empty_line, no_ack_exception;
	rfaf_addr_t rx_addr_type, ack_type, tx_addr_type;
	logic [7:0] rx_seq, ack_seq, tx_seq, s;
	logic [15:0] rx_cust, tx_cust;
	logic [44:0] exp_q[$];
	logic [44:0] e;
	int err_count = 0, compares = 0, launches = 0, excs = 0, n0, x0, i;

	rfaf_filter_ack #(.FACTORY_UID(FID), .CUSTOMER_CODE(CC), .ACK_WAIT_CYCLES(20), .MAX_RETRIES(MAXR)) rfaf_filter_ack_i (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_hdr_valid(rx_hdr_valid),
		.rx_addr_type(rx_addr_type), .rx_is_ack(rx_is_ack), .rx_ack_req(rx_ack_req), .rx_seq(rx_seq),
		.rx_src(rx_src), .rx_dst(rx_dst), .rx_cust(rx_cust), .rx_deliver(rx_deliver), .rx_discard(rx_discard),
		.ack_send(ack_send), .ack_type(ack_type), .ack_dst(ack_dst), .ack_seq(ack_seq),
		.tx_pkt_valid(tx_pkt_valid), .tx_addr_type(tx_addr_type), .tx_ack_req(tx_ack_req), .tx_seq(tx_seq),
		.tx_src(tx_src), .tx_dst(tx_dst), .tx_cust(tx_cust), .tx_done(tx_done),
		.buffer_empty_line(buffer_empty_line), .no_ack_exception(no_ack_exception));

	rfaf_peer peer_i (.pclk(pclk), .tx_pkt_valid(tx_pkt_valid), .tx_addr_type(tx_addr_type),
		.tx_ack_req(tx_ack_req), .tx_seq(tx_seq), .tx_src(tx_src), .tx_dst(tx_dst), .tx_cust(tx_cust),
		.tx_done(tx_done), .rx_hdr_valid(rx_hdr_valid), .rx_addr_type(rx_addr_type), .rx_is_ack(rx_is_ack),
		.rx_ack_req(rx_ack_req), .rx_seq(rx_seq), .rx_src(rx_src), .rx_dst(rx_dst), .rx_cust(rx_cust));

	initial begin
		forever #2.5 pclk = ~pclk;
	end

	task complete_run;
		if (err_count == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : complete_run

	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		{psel, penable, pwrite} <= {1'b1, 1'b0, wr};
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// only the watchdog ends a stuck wait
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		last_err = pslverr;
		{psel, penable} <= 2'b00;
	endtask : apb

	// x = {deliver, discard, ack}; an ack goes back to the packet's source with its type and id
	task rx(input rfaf_addr_t t, input logic r, input logic [31:0] sr, input logic [31:0] d, input logic [15:0] c,
		input logic [7:0] sq, input logic [2:0] x);
		exp_q.push_back({x, x[0] ? {t, sq, sr} : 42'h0});
		peer_i.send_hdr(t, r, sq, sr, d, c);
	endtask : rx

	always @(posedge pclk) begin
		if (rx_deliver | rx_discard | ack_send) begin
			e = exp_q.size() ? exp_q.pop_front() : '1;
			`CHK({rx_deliver, rx_discard, ack_send, ack_send ? {ack_type, ack_seq, ack_dst} : 42'h0}, e, "rx outcome")
		end
		if (tx_pkt_valid)
			launches++;
		if (no_ack_exception)
			excs++;
	end

	initial begin
		#100us;
		err_count++;
		complete_run();
	end

	initial begin
		void'($urandom(2853));
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, `RFAF_OFF_NETMODE, 0);
		`CHK(rd, 32'h04, "mode reset")
		apb(0, `RFAF_OFF_USER_MASK, 0);
		`CHK(rd, `RFAF_ALL_ONES, "mask reset")
		apb(1, `RFAF_OFF_MY_UID, 32'h1);
		apb(0, `RFAF_OFF_MY_UID, 0);
		`CHK(rd, FID, "id write")
		apb(1, `RFAF_OFF_CUST, 32'h1);
		apb(0, `RFAF_OFF_CUST, 0);
		`CHK(rd, {16'h0, CC}, "customer code")
		apb(0, 12'h0fc, 0);
		`CHK(last_err, 1'b1, "unmapped")
		s = 8'($urandom);
		rx(rfaf_addr_uid, 1, 32'h1000, FID, 0, s, 3'b101);
		rx(rfaf_addr_uid, 1, 32'h1000, FID, 0, s, 3'b011);
		rx(rfaf_addr_uid, 0, 32'h1000, 32'h3000, 0, 8'($urandom), 3'b010);
		rx(rfaf_addr_uid, 1, 32'h1001, `RFAF_UID_BCAST, 0, 8'($urandom), 3'b100);
		apb(1, `RFAF_OFF_USER_SRC, 32'h3000);
		apb(1, `RFAF_OFF_USER_MASK, 32'he000);
		// ids kept distinct: same source and id would be taken for a repeat
		rx(rfaf_addr_user, 1, 32'h1000, 32'h3000, CC, 8'(s + 8'h01), 3'b101);
		rx(rfaf_addr_user, 1, 32'h1000, 32'h2000, CC, 8'(s + 8'h02), 3'b100);
		rx(rfaf_addr_user, 0, 32'h1000, 32'h4000, CC, 8'($urandom), 3'b010);
		rx(rfaf_addr_user, 0, 32'h1000, 32'he000, CC, 8'($urandom), 3'b100);
		rx(rfaf_addr_user, 1, 32'h1000, 32'h3000, ~CC, 8'($urandom), 3'b010);
		apb(1, `RFAF_OFF_USER_SRC, 32'h30000001);
		apb(1, `RFAF_OFF_USER_MASK, 32'he0000000);
		rx(rfaf_addr_ext, 1, 32'h10000000, 32'h30000001, CC, 8'($urandom), 3'b101);
		apb(1, `RFAF_OFF_USER_MASK, `RFAF_ALL_ONES);
		rx(rfaf_addr_ext, 0, 32'h10000000, 32'h30000002, CC, 8'($urandom), 3'b010);
		apb(1, `RFAF_OFF_AUTOADDR, 32'h1);
		rx(rfaf_addr_uid, 0, 32'h4444, FID, 0, 8'($urandom), 3'b100);
		repeat (2) @(posedge pclk);
		apb(0, `RFAF_OFF_UID_DEST, 0);
		`CHK(rd, 32'h4444, "auto address")
		apb(1, `RFAF_OFF_AUTOADDR, 32'h0);
		apb(1, `RFAF_OFF_UID_DEST, 32'h3000);
		apb(1, `RFAF_OFF_USER_DEST, 32'h30000001);
		apb(1, `RFAF_OFF_USER_SRC, 32'h10000000);
		foreach (MODES[k]) begin
			peer_i.ack_dly = (MODES[k][2:0] == 3'h6) ? 12 : 1;
			apb(1, `RFAF_OFF_NETMODE, {24'h0, MODES[k]});
			n0 = launches;
			s = tx_seq;
			apb(1, `RFAF_OFF_TXQ, 32'h1);
			@(posedge pclk);
			`CHK(buffer_empty_line, 1'b0, "block pending")
			for (i = 0; i < 300 && buffer_empty_line !== 1'b1; i++)
				@(posedge pclk);
			w = (MODES[k][2:0] == 3'h6) ? 32'h0000ffff : `RFAF_ALL_ONES;
			ts = (MODES[k][2:0] == 3'h4) ? FID : 32'h10000000 & w;
			td = (MODES[k][2:0] == 3'h4) ? 32'h3000 : 32'h30000001 & w;
			`CHK(launches - n0, 1, "single launch")
			`CHK(tx_ack_req, MODES[k][4], "ack request")
			`CHK(tx_addr_type, (MODES[k][2:0] == 3'h4) ? rfaf_addr_uid : (MODES[k][0] ? rfaf_addr_ext : rfaf_addr_user), "type")
			`CHK({tx_src & w, tx_dst & w}, {ts, td}, "tx addresses")
			`CHK(tx_seq, 8'(s + 8'h01), "new block id")
			if (MODES[k][2:0] != 3'h4)
				`CHK(tx_cust, CC, "tx customer code")
		end
		peer_i.ack_dly = 0;
		apb(1, `RFAF_OFF_NETMODE, 32'h14);
		n0 = launches;
		x0 = excs;
		apb(1, `RFAF_OFF_TXQ, 32'h1);
		@(posedge pclk);
		for (i = 0; i < 1000 && buffer_empty_line !== 1'b1; i++)
			@(posedge pclk);
		// one more edge so the monitor has counted the exception pulse
		@(posedge pclk);
		`CHK(launches - n0, 1 + MAXR, "retries")
		`CHK(excs - x0, 1, "exception pulse")
		apb(0, `RFAF_OFF_STATUS, 0);
		`CHK(rd[15:0], {`RFAF_EX_NO_ACK, 8'h01}, "status code")
		apb(0, `RFAF_OFF_STATUS, 0);
		`CHK(rd[15:8], 8'h00, "code cleared")
		`CHK(exp_q.size(), 0, "missing rx outcome")
		complete_run();
	end
endmodule : rf_address_filter_ack_test

`default_nettype wire
